// ==== shared/rstc_defines.svh ====
// Named constants for the reset cause and time-out logic.
// Assumes inclusion by bare name from the design and test files.
`ifndef RSTC_DEFINES_SVH
`define RSTC_DEFINES_SVH

// Register addresses on the 8-bit register port
`define ADDR_PC_LOW 8'h02
`define ADDR_STATUS 8'h03
`define ADDR_PC_LATCH 8'h0a
`define ADDR_OPTION 8'h81
`define ADDR_PORTA_DIR 8'h85
`define ADDR_PORTC_DIR 8'h87
`define ADDR_CAUSE 8'h8e
`define ADDR_EVT_STATUS 8'hf0
`define ADDR_EVT_MASK 8'hf1

// Field positions
`define ST_TIMEOUT_BIT 4
`define ST_POWERDOWN_BIT 3
`define CAUSE_POR_BIT 1
`define CAUSE_BROWNOUT_BIT 0

// Reset values
`define STATUS_POR_VAL 8'h18
`define CAUSE_POR_VAL 2'h0
`define CAUSE_BROWNOUT_VAL 2'h2
`define ZERO8 8'h00
`define ONES8 8'hff
`define ONES6 6'h3f
`define PC_LATCH_CLR 5'h00
`define PC_RESET 13'h0000
`define PC_ONE 13'h0001
`define PC_VECTOR 13'h0004

// Event bits of the interrupt status register
`define EVT_W 5
`define EVT_POR 0
`define EVT_BROWNOUT 1
`define EVT_EXT 2
`define EVT_WATCHDOG 3
`define EVT_WAKE 4

// Timing
`define CORE_CLK_MHZ 125
`define PWRT_TIME_MS 72
`define OST_OSC_CYCLES 1024
`define PWRT_CNT_W 24
`define OST_CNT_W 11

`endif

// ==== shared/rstc_pkg.sv ====
// Types shared by the reset cause and time-out logic.
// Assumes nothing beyond a SystemVerilog compiler.
package rstc_pkg;
  // Start-up sequence phases
  typedef enum logic [1:0] {SEQ_BOOT, SEQ_PWRT, SEQ_OST, SEQ_RUN} seq_state_t;
endpackage

// ==== src/delay_counter.sv ====
// Down counter that times one delay in ticks of a given strobe.
// Assumes the caller pulses start for one cycle; a new start restarts it.
`timescale 1ns/10ps
module delay_counter #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;

  // Restart wins over counting so a repeated brown-out re-arms the delay
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (start) begin
      cnt_nxt = load;
      busy_nxt = 1'b1;
    end else if (busy_r && tick) begin
      if (cnt_r <= W'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (en) begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule

// ==== src/event_capture.sv ====
// Sticky event flags with a mask and one level interrupt request.
// Assumes set and read-clear arrive in the core clock domain.
`timescale 1ns/10ps
module event_capture #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [W-1:0] set,
  input wire logic clr,
  input wire logic mask_wr,
  input wire logic [W-1:0] mask_wdata,
  output logic [W-1:0] flags,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] flags_r, flags_nxt;
  logic [W-1:0] mask_r, mask_nxt;
  logic irq_r, irq_nxt;

  // A set in the clearing cycle survives the clear
  always_comb begin
    flags_nxt = (clr ? '0 : flags_r) | set;
    mask_nxt = mask_wr ? mask_wdata : mask_r;
    irq_nxt = |(flags_nxt & mask_nxt);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else if (en) begin
      flags_r <= flags_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign flags = flags_r;
  assign mask = mask_r;
  assign irq = irq_r;
endmodule

// ==== src/reset_cause_and_timeout_logic.sv ====
// Reset cause recording, start-up delay selection and reset register values.
// Assumes all inputs are synchronous to CORE_CLK; RESET_N is the power-on reset.
//
// Overview of operation
// - The cause register holds only a power-on flag in bit 1 and a brown-out flag in bit 0, other bits read zero.
// - The brown-out flag starts undefined, software may write it to one, and a brown-out reset clears it.
// - With brown-out detection disabled the brown-out flag has no defined meaning.
// - Power-on reset clears the power-on flag, a brown-out sets it, other resets leave it, and software sets it again afterwards.
// - Crystal modes wait the power-up timer plus 1024 oscillator periods, other modes the timer alone.
// - Power-on gives flags 0/u with time-out and power-down set; brown-out gives flags 1/0 with both set.
// - A reset-pin reset in sleep loads address zero, sets time-out, clears power-down, keeps the flags.
// - A reset-pin reset when awake loads address zero, clears the top three status bits, keeps the rest.
// - An interrupt wake-up resumes at the next address, sets time-out and clears power-down.
// - A watchdog reset clears time-out and the top three status bits; a watchdog wake-up resumes at the next address and clears both.
// - An interrupt wake-up with interrupts enabled runs one instruction then branches to the vector.
// - Power-on leaves the status register at 0001 1xxx and the cause register at 0x.
// - Non-wake resets clear the counter low byte and latch and set option and both direction registers.
// - The power-up timer holds reset for a nominal 72 ms after power-on or brown-out.
// - The oscillator start-up delay counts 1024 oscillator ticks after the power-up timer ends.
`timescale 1ns/10ps
`include "rstc_defines.svh"
module reset_cause_and_timeout_logic #(
  parameter int PWRT_CYCLES = `PWRT_TIME_MS * 1000 * `CORE_CLK_MHZ
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OSC_TICK,
  input wire logic CRYSTAL_MODE,
  input wire logic POWERUP_TIMER_DISABLE,
  input wire logic BROWNOUT_DETECT_ENABLE,
  input wire logic BROWNOUT_EVENT,
  input wire logic EXT_RESET_PIN_N,
  input wire logic WATCHDOG_EVENT,
  input wire logic WAKE_IRQ_EVENT,
  input wire logic SLEEPING,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  input wire logic STEP_DONE,
  input wire logic [12:0] PC_IN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic CORE_HOLD,
  output logic PC_LOAD,
  output logic [12:0] PC_VALUE,
  output logic IRQ
);
  localparam logic [`PWRT_CNT_W-1:0] PWRT_LOAD = `PWRT_CNT_W'(PWRT_CYCLES);
  localparam logic [`OST_CNT_W-1:0] OST_LOAD = `OST_CNT_W'(`OST_OSC_CYCLES);

  // Sequencer and register state
  rstc_pkg::seq_state_t state_r, state_nxt;
  logic [7:0] status_r, status_nxt;
  logic [1:0] cause_r, cause_nxt;
  logic [7:0] pc_low_r, pc_low_nxt;
  logic [4:0] pc_latch_r, pc_latch_nxt;
  logic [7:0] option_r, option_nxt;
  logic [5:0] porta_dir_r, porta_dir_nxt;
  logic [5:0] portc_dir_r, portc_dir_nxt;
  logic [12:0] pend_pc_r, pend_pc_nxt;
  logic vec_pend_r, vec_pend_nxt;
  logic hold_r, hold_nxt;
  logic pc_load_r, pc_load_nxt;
  logic [12:0] pc_value_r, pc_value_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pin_prev_r;

  // Decoded strobes and events
  logic brownout_ev, ext_ev, watchdog_ev, wake_ev, por_ev;
  logic pwrt_start, ost_start;
  logic pwrt_busy, pwrt_done, ost_busy, ost_done;
  logic [`EVT_W-1:0] evt_set, evt_flags, evt_mask;
  logic evt_clr, evt_mask_wr, irq_w;
  logic wr_status, wr_cause;

  // Brown-out only counts while the detector is enabled
  assign brownout_ev = BROWNOUT_EVENT && BROWNOUT_DETECT_ENABLE;
  assign ext_ev = pin_prev_r && !EXT_RESET_PIN_N;
  assign watchdog_ev = WATCHDOG_EVENT && !brownout_ev;
  assign wake_ev = WAKE_IRQ_EVENT && SLEEPING && !brownout_ev && !ext_ev && !watchdog_ev;
  assign por_ev = (state_r == rstc_pkg::SEQ_BOOT);
  assign wr_status = WR && (ADDR == `ADDR_STATUS);
  assign wr_cause = WR && (ADDR == `ADDR_CAUSE);

  // Time-out starts: power-up timer unless disabled, else straight to the crystal delay
  always_comb begin
    pwrt_start = 1'b0;
    ost_start = 1'b0;
    if (por_ev || brownout_ev) begin
      pwrt_start = !POWERUP_TIMER_DISABLE;
      ost_start = POWERUP_TIMER_DISABLE && CRYSTAL_MODE;
    end else if (state_r == rstc_pkg::SEQ_PWRT && pwrt_done) begin
      ost_start = CRYSTAL_MODE;
    end else if (state_r == rstc_pkg::SEQ_RUN && SLEEPING && (wake_ev || watchdog_ev)) begin
      ost_start = CRYSTAL_MODE;
    end
  end

  // Power-up timer runs on core clock cycles as a stand-in for its own slow clock
  delay_counter #(
    .W(`PWRT_CNT_W)
  ) u_pwrt (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .en(CLK_EN),
    .start(pwrt_start),
    .tick(1'b1),
    .load(PWRT_LOAD),
    .busy(pwrt_busy),
    .done(pwrt_done)
  );

  // Oscillator start-up delay counts oscillator ticks, not core cycles
  delay_counter #(
    .W(`OST_CNT_W)
  ) u_ost (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .en(CLK_EN),
    .start(ost_start),
    .tick(OSC_TICK),
    .load(OST_LOAD),
    .busy(ost_busy),
    .done(ost_done)
  );

  // Sequencer: boot, timer, oscillator wait, run
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rstc_pkg::SEQ_BOOT: begin
        if (!POWERUP_TIMER_DISABLE) begin
          state_nxt = rstc_pkg::SEQ_PWRT;
        end else if (CRYSTAL_MODE) begin
          state_nxt = rstc_pkg::SEQ_OST;
        end else begin
          state_nxt = rstc_pkg::SEQ_RUN;
        end
      end
      rstc_pkg::SEQ_PWRT: begin
        if (pwrt_done) begin
          state_nxt = CRYSTAL_MODE ? rstc_pkg::SEQ_OST : rstc_pkg::SEQ_RUN;
        end
      end
      rstc_pkg::SEQ_OST: begin
        if (ost_done) begin
          state_nxt = rstc_pkg::SEQ_RUN;
        end
      end
      rstc_pkg::SEQ_RUN: begin
        if (ost_start) begin
          state_nxt = rstc_pkg::SEQ_OST;
        end
      end
    endcase
    // A brown-out restarts the whole delay from any phase
    if (brownout_ev) begin
      if (!POWERUP_TIMER_DISABLE) begin
        state_nxt = rstc_pkg::SEQ_PWRT;
      end else if (CRYSTAL_MODE) begin
        state_nxt = rstc_pkg::SEQ_OST;
      end else begin
        state_nxt = rstc_pkg::SEQ_RUN;
      end
    end
  end

  // Register values per reset kind; cause flags only move on clock edges after release
  always_comb begin
    status_nxt = status_r;
    cause_nxt = cause_r;
    pc_low_nxt = pc_low_r;
    pc_latch_nxt = pc_latch_r;
    option_nxt = option_r;
    porta_dir_nxt = porta_dir_r;
    portc_dir_nxt = portc_dir_r;
    pend_pc_nxt = pend_pc_r;
    vec_pend_nxt = vec_pend_r;
    // Software writes; time-out and power-down cannot be written
    if (wr_status) begin
      status_nxt = {WDATA[7:5], status_r[`ST_TIMEOUT_BIT], status_r[`ST_POWERDOWN_BIT], WDATA[2:0]};
    end
    if (wr_cause) begin
      cause_nxt = WDATA[1:0];
    end
    if (WR && ADDR == `ADDR_PC_LOW) begin
      pc_low_nxt = WDATA;
    end
    if (WR && ADDR == `ADDR_PC_LATCH) begin
      pc_latch_nxt = WDATA[4:0];
    end
    if (WR && ADDR == `ADDR_OPTION) begin
      option_nxt = WDATA;
    end
    if (WR && ADDR == `ADDR_PORTA_DIR) begin
      porta_dir_nxt = WDATA[5:0];
    end
    if (WR && ADDR == `ADDR_PORTC_DIR) begin
      portc_dir_nxt = WDATA[5:0];
    end
    // Hardware events override software writes in the same cycle
    if (por_ev) begin
      status_nxt = `STATUS_POR_VAL;
      cause_nxt[`CAUSE_POR_BIT] = 1'b0;
    end else if (brownout_ev) begin
      status_nxt = {3'h0, 1'b1, 1'b1, status_r[2:0]};
      cause_nxt = `CAUSE_BROWNOUT_VAL;
    end else if (ext_ev && SLEEPING) begin
      status_nxt = {3'h0, 1'b1, 1'b0, status_r[2:0]};
    end else if (ext_ev) begin
      status_nxt = {3'h0, status_r[4:0]};
    end else if (watchdog_ev && SLEEPING) begin
      status_nxt[`ST_TIMEOUT_BIT] = 1'b0;
      status_nxt[`ST_POWERDOWN_BIT] = 1'b0;
    end else if (watchdog_ev) begin
      status_nxt = {3'h0, 1'b0, status_r[3:0]};
    end else if (wake_ev) begin
      status_nxt[`ST_TIMEOUT_BIT] = 1'b1;
      status_nxt[`ST_POWERDOWN_BIT] = 1'b0;
    end
    // Non-wake resets reload the counter path and port setup; wake-ups keep them
    if (por_ev || brownout_ev || ext_ev || (watchdog_ev && !SLEEPING)) begin
      pc_low_nxt = `ZERO8;
      pc_latch_nxt = `PC_LATCH_CLR;
      option_nxt = `ONES8;
      porta_dir_nxt = `ONES6;
      portc_dir_nxt = `ONES6;
      pend_pc_nxt = `PC_RESET;
      vec_pend_nxt = 1'b0;
    end else if (SLEEPING && (wake_ev || watchdog_ev)) begin
      pend_pc_nxt = PC_IN + `PC_ONE;
      vec_pend_nxt = wake_ev && GLOBAL_INTERRUPT_ENABLE;
    end
    if (pc_load_r) begin
      pc_low_nxt = pc_value_r[7:0];
    end
    if (vec_pend_r && !hold_r && !pc_load_r && STEP_DONE) begin
      vec_pend_nxt = 1'b0;
    end
  end

  // Core hold and program counter loads; the pin holds the core even after the delays end
  always_comb begin
    hold_nxt = (state_nxt != rstc_pkg::SEQ_RUN) || !EXT_RESET_PIN_N || brownout_ev;
    if (watchdog_ev && !SLEEPING) begin
      hold_nxt = 1'b1;
    end
    pc_load_nxt = 1'b0;
    pc_value_nxt = pc_value_r;
    if (hold_r && !hold_nxt) begin
      pc_load_nxt = 1'b1;
      pc_value_nxt = pend_pc_r;
    end else if (SLEEPING && (wake_ev || watchdog_ev) && state_nxt == rstc_pkg::SEQ_RUN) begin
      pc_load_nxt = 1'b1; // Non-crystal wake resumes with no delay
      pc_value_nxt = PC_IN + `PC_ONE;
    end else if (vec_pend_r && !hold_r && !pc_load_r && STEP_DONE) begin
      pc_load_nxt = 1'b1;
      pc_value_nxt = `PC_VECTOR;
    end
  end

  // Read data for the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_nxt = `ZERO8;
    if (RD) begin
      unique case (ADDR)
        `ADDR_PC_LOW: rdata_nxt = pc_low_r;
        `ADDR_STATUS: rdata_nxt = status_r;
        `ADDR_PC_LATCH: rdata_nxt = {3'h0, pc_latch_r};
        `ADDR_OPTION: rdata_nxt = option_r;
        `ADDR_PORTA_DIR: rdata_nxt = {2'h0, porta_dir_r};
        `ADDR_PORTC_DIR: rdata_nxt = {2'h0, portc_dir_r};
        `ADDR_CAUSE: rdata_nxt = {6'h00, cause_r};
        `ADDR_EVT_STATUS: rdata_nxt = {3'h0, evt_flags};
        `ADDR_EVT_MASK: rdata_nxt = {3'h0, evt_mask};
        default: rdata_nxt = `ZERO8;
      endcase
    end
  end

  // Interrupt events mirror each reset cause
  always_comb begin
    evt_set = '0;
    evt_set[`EVT_POR] = por_ev;
    evt_set[`EVT_BROWNOUT] = brownout_ev;
    evt_set[`EVT_EXT] = ext_ev;
    evt_set[`EVT_WATCHDOG] = watchdog_ev;
    evt_set[`EVT_WAKE] = wake_ev;
  end
  assign evt_clr = RD && (ADDR == `ADDR_EVT_STATUS);
  assign evt_mask_wr = WR && (ADDR == `ADDR_EVT_MASK);

  event_capture #(
    .W(`EVT_W)
  ) u_evt (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .en(CLK_EN),
    .set(evt_set),
    .clr(evt_clr),
    .mask_wr(evt_mask_wr),
    .mask_wdata(WDATA[`EVT_W-1:0]),
    .flags(evt_flags),
    .mask(evt_mask),
    .irq(irq_w)
  );

  // State registers; the power-on values here are what the boot step then confirms
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= rstc_pkg::SEQ_BOOT;
      status_r <= `STATUS_POR_VAL;
      cause_r <= `CAUSE_POR_VAL;
      pc_low_r <= `ZERO8;
      pc_latch_r <= `PC_LATCH_CLR;
      option_r <= `ONES8;
      porta_dir_r <= `ONES6;
      portc_dir_r <= `ONES6;
      pend_pc_r <= `PC_RESET;
      vec_pend_r <= 1'b0;
      hold_r <= 1'b1;
      pc_load_r <= 1'b0;
      pc_value_r <= `PC_RESET;
      rdata_r <= `ZERO8;
      pin_prev_r <= 1'b1;
    end else if (CLK_EN) begin
      state_r <= state_nxt;
      status_r <= status_nxt;
      cause_r <= cause_nxt;
      pc_low_r <= pc_low_nxt;
      pc_latch_r <= pc_latch_nxt;
      option_r <= option_nxt;
      porta_dir_r <= porta_dir_nxt;
      portc_dir_r <= portc_dir_nxt;
      pend_pc_r <= pend_pc_nxt;
      vec_pend_r <= vec_pend_nxt;
      hold_r <= hold_nxt;
      pc_load_r <= pc_load_nxt;
      pc_value_r <= pc_value_nxt;
      rdata_r <= rdata_nxt;
      pin_prev_r <= EXT_RESET_PIN_N;
    end
  end

  assign RDATA = rdata_r;
  assign CORE_HOLD = hold_r;
  assign PC_LOAD = pc_load_r;
  assign PC_VALUE = pc_value_r;
  assign IRQ = irq_w;
endmodule

// ==== test/rstc_asserts.sv ====
// Concurrent checks on the ports of the reset cause and time-out logic.
// Assumes a bind onto the top module and one core clock domain.
`timescale 1ns/10ps
`include "rstc_defines.svh"
module rstc_asserts #(
  parameter int PWRT_CYCLES = 20
) (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic OSC_TICK,
  input wire logic CRYSTAL_MODE,
  input wire logic POWERUP_TIMER_DISABLE,
  input wire logic BROWNOUT_DETECT_ENABLE,
  input wire logic BROWNOUT_EVENT,
  input wire logic EXT_RESET_PIN_N,
  input wire logic WATCHDOG_EVENT,
  input wire logic WAKE_IRQ_EVENT,
  input wire logic SLEEPING,
  input wire logic GLOBAL_INTERRUPT_ENABLE,
  input wire logic STEP_DONE,
  input wire logic [12:0] PC_IN,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic CORE_HOLD,
  input wire logic PC_LOAD,
  input wire logic [12:0] PC_VALUE,
  input wire logic IRQ
);
  // One cycle of slack: the hold may start on the event edge or the next
  localparam int PMIN = PWRT_CYCLES - 1;
  logic bo_r;
  logic bo_nxt;
  int cnt_r;
  int cnt_nxt;

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  // Hold cycles since the last accepted brown-out, which restarts the count
  always_comb begin
    bo_nxt = bo_r;
    cnt_nxt = cnt_r;
    if (BROWNOUT_EVENT && BROWNOUT_DETECT_ENABLE) begin
      bo_nxt = 1'h1;
      cnt_nxt = 0;
    end else if (PC_LOAD) begin
      bo_nxt = 1'h0;
    end else if (CORE_HOLD) begin
      cnt_nxt = cnt_r + 1;
    end
  end

  // Helper registers only
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bo_r <= 1'h0;
      cnt_r <= 0;
    end else begin
      bo_r <= bo_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_rdata_idle: assert property ($past(CLK_EN && !RD) |-> RDATA == 8'h00)
    else $error("read data not zero without a read");
  a_cause_width: assert property ($past(RD && ADDR == 8'h8e) |-> RDATA[7:2] == 6'h00)
    else $error("cause register upper bits not zero");
  a_latch_width: assert property ($past(RD && ADDR == 8'h0a) |-> RDATA[7:5] == 3'h0)
    else $error("counter latch upper bits not zero");
  a_load_release: assert property ($fell(CORE_HOLD) |-> PC_LOAD)
    else $error("hold released without a counter load");
  a_pin_hold: assert property (!EXT_RESET_PIN_N [*4] |-> CORE_HOLD)
    else $error("core not held while reset pin low");
  a_bo_hold: assert property (BROWNOUT_EVENT && BROWNOUT_DETECT_ENABLE |-> ##[1:2] CORE_HOLD)
    else $error("brown-out did not hold the core");
  a_pwrt_min: assert property (PC_LOAD && bo_r && !POWERUP_TIMER_DISABLE |-> cnt_r >= PMIN)
    else $error("power-up timer hold too short");
  a_wake_load: assert property (SLEEPING && WAKE_IRQ_EVENT && !CRYSTAL_MODE && !CORE_HOLD && !BROWNOUT_EVENT
    && !WATCHDOG_EVENT && EXT_RESET_PIN_N |-> ##[1:2] (PC_LOAD && PC_VALUE == PC_IN + 13'h0001))
    else $error("wake did not resume at next address");
  a_wdt_load: assert property (WATCHDOG_EVENT && !SLEEPING && !CORE_HOLD && !BROWNOUT_EVENT && EXT_RESET_PIN_N
    |-> ##[1:3] (PC_LOAD && PC_VALUE == `PC_RESET))
    else $error("watchdog reset did not load address zero");
endmodule

bind reset_cause_and_timeout_logic rstc_asserts #(.PWRT_CYCLES(PWRT_CYCLES)) u_rstc_asserts (.CORE_CLK, .RESET_N,
  .CLK_EN, .OSC_TICK, .CRYSTAL_MODE, .POWERUP_TIMER_DISABLE, .BROWNOUT_DETECT_ENABLE, .BROWNOUT_EVENT,
  .EXT_RESET_PIN_N, .WATCHDOG_EVENT, .WAKE_IRQ_EVENT, .SLEEPING, .GLOBAL_INTERRUPT_ENABLE, .STEP_DONE, .PC_IN,
  .ADDR, .WDATA, .WR, .RD, .RDATA, .CORE_HOLD, .PC_LOAD, .PC_VALUE, .IRQ);

// ==== test/tb_reset_cause_and_timeout_logic.sv ====
// Self-checking bench for the reset cause and time-out logic.
// Assumes a short power-up timer and the checker bound by its own file.
`timescale 1ns/10ps
`include "rstc_defines.svh"
module tb_reset_cause_and_timeout_logic;
  localparam int PW = 20;
  logic CORE_CLK, RESET_N, CLK_EN, OSC_TICK, CRYSTAL_MODE, POWERUP_TIMER_DISABLE, BROWNOUT_DETECT_ENABLE;
  logic BROWNOUT_EVENT, EXT_RESET_PIN_N, WATCHDOG_EVENT, WAKE_IRQ_EVENT, SLEEPING, GLOBAL_INTERRUPT_ENABLE;
  logic STEP_DONE, WR, RD, CORE_HOLD, PC_LOAD, IRQ;
  logic [12:0] PC_IN, PC_VALUE;
  logic [7:0] ADDR, WDATA, RDATA;
  int err_count, n_checks, hold_n, tick_n;

  reset_cause_and_timeout_logic #(.PWRT_CYCLES(PW)) u_reset_cause_and_timeout_logic (.CORE_CLK, .RESET_N,
    .CLK_EN, .OSC_TICK, .CRYSTAL_MODE, .POWERUP_TIMER_DISABLE, .BROWNOUT_DETECT_ENABLE, .BROWNOUT_EVENT,
    .EXT_RESET_PIN_N, .WATCHDOG_EVENT, .WAKE_IRQ_EVENT, .SLEEPING, .GLOBAL_INTERRUPT_ENABLE, .STEP_DONE, .PC_IN,
    .ADDR, .WDATA, .WR, .RD, .RDATA, .CORE_HOLD, .PC_LOAD, .PC_VALUE, .IRQ);

  // 125 MHz core clock
  always #4 CORE_CLK = ~CORE_CLK;

  // Tick every other cycle so the start-up count is clearly longer than the timer
  always @(posedge CORE_CLK) OSC_TICK <= ~OSC_TICK;

  // Hold length and ticks; kept through the load cycle so ld can still see them
  always @(posedge CORE_CLK) begin
    if (CORE_HOLD) begin
      hold_n++;
      tick_n += OSC_TICK;
    end else if (!PC_LOAD) begin
      hold_n = 0;
      tick_n = 0;
    end
  end

  task final_report;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [12:0] g, input logic [12:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge CORE_CLK);
    WR <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CORE_CLK);
    RD <= 1'h0;
    #1;
    chk({5'h00, RDATA}, {5'h00, e});
  endtask

  // Pulse one event for a cycle; code 4 holds the reset pin low for five samples
  task ev(input int k);
    @(posedge CORE_CLK);
    BROWNOUT_EVENT <= (k == 0);
    WATCHDOG_EVENT <= (k == 1);
    WAKE_IRQ_EVENT <= (k == 2);
    STEP_DONE <= (k == 3);
    EXT_RESET_PIN_N <= (k != 4);
    if (k == 4) repeat (4) @(posedge CORE_CLK);
    @(posedge CORE_CLK);
    BROWNOUT_EVENT <= 1'h0;
    WATCHDOG_EVENT <= 1'h0;
    WAKE_IRQ_EVENT <= 1'h0;
    STEP_DONE <= 1'h0;
    EXT_RESET_PIN_N <= 1'h1;
  endtask

  // Bounded wait for the counter load, then compare the loaded address
  task ld(input logic [12:0] pc);
    int n;
    n = 0;
    #1;
    while (!PC_LOAD && n < 5000) begin
      @(posedge CORE_CLK);
      #1;
      n++;
    end
    chk({12'h000, PC_LOAD}, 13'h0001);
    chk(PC_VALUE, pc);
  endtask

  // A hang counts as a mismatch and ends the run the usual way
  initial begin
    #100000;
    err_count++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report;
  end

  initial begin
    CORE_CLK = 1'h0;
    RESET_N = 1'h0;
    CLK_EN = 1'h1;
    OSC_TICK = 1'h0;
    CRYSTAL_MODE = 1'h1;
    POWERUP_TIMER_DISABLE = 1'h0;
    BROWNOUT_DETECT_ENABLE = 1'h1;
    {BROWNOUT_EVENT, WATCHDOG_EVENT, WAKE_IRQ_EVENT, SLEEPING, STEP_DONE, WR, RD} = 7'h00;
    EXT_RESET_PIN_N = 1'h1;
    GLOBAL_INTERRUPT_ENABLE = 1'h1;
    PC_IN = 13'h0123;
    ADDR = 8'h00;
    WDATA = 8'h00;
    repeat (6) @(posedge CORE_CLK);
    RESET_N <= 1'h1;
    // Power-on in crystal mode: timer, then the oscillator count
    ld(`PC_RESET);
    chk({12'h000, tick_n >= 1024 && tick_n <= 1024 + PW}, 13'h0001);
    @(posedge CORE_CLK);
    CRYSTAL_MODE <= 1'h0;
    rd(8'h03, 8'h18);
    rd(8'h8e, 8'h00);
    rd(8'h81, 8'hff);
    rd(8'h85, 8'h3f);
    rd(8'h87, 8'h3f);
    rd(8'h0a, 8'h00);
    rd(8'h02, 8'h00);
    wr(8'h8e, 8'hff);
    rd(8'h8e, 8'h03);
    wr(8'h40, 8'h55);
    rd(8'h40, 8'h00);
    // Only the pin event is unmasked, so the power-on flag alone keeps the request low
    wr(`ADDR_EVT_MASK, 8'h04);
    rd(`ADDR_EVT_MASK, 8'h04);
    chk({12'h000, IRQ}, 13'h0000);
    wr(8'h03, 8'he5);
    rd(8'h03, 8'hfd);
    // Pin reset while awake
    ev(4);
    ld(`PC_RESET);
    rd(8'h03, 8'h1d);
    rd(8'h8e, 8'h03);
    chk({12'h000, IRQ}, 13'h0001);
    rd(`ADDR_EVT_STATUS, 8'h05);
    repeat (2) @(posedge CORE_CLK);
    #1;
    chk({12'h000, IRQ}, 13'h0000);
    // Watchdog reset while awake
    wr(8'h03, 8'he5);
    ev(1);
    ld(`PC_RESET);
    rd(8'h03, 8'h0d);
    // Pin reset during sleep
    @(posedge CORE_CLK);
    SLEEPING <= 1'h1;
    ev(4);
    ld(`PC_RESET);
    rd(8'h03, 8'h15);
    rd(8'h8e, 8'h03);
    // Watchdog then interrupt wake-up; option must survive both
    wr(8'h81, 8'h00);
    wr(8'h03, 8'he5);
    ev(1);
    ld(13'h0124);
    rd(8'h03, 8'he5);
    ev(2);
    ld(13'h0124);
    @(posedge CORE_CLK);
    SLEEPING <= 1'h0;
    ev(3);
    ld(`PC_VECTOR);
    rd(8'h03, 8'hf5);
    rd(8'h81, 8'h00);
    // Brown-out with the power-up timer
    wr(8'h85, 8'h00);
    ev(0);
    ld(`PC_RESET);
    chk({12'h000, hold_n >= PW - 1 && hold_n <= PW + 3}, 13'h0001);
    rd(8'h8e, 8'h02);
    rd(8'h03, 8'h1d);
    rd(8'h81, 8'hff);
    rd(8'h85, 8'h3f);
    wr(8'h8e, 8'h03);
    rd(8'h8e, 8'h03);
    // Detector off: the event is dropped
    @(posedge CORE_CLK);
    BROWNOUT_DETECT_ENABLE <= 1'h0;
    ev(0);
    repeat (4) @(posedge CORE_CLK);
    rd(8'h8e, 8'h03);
    chk({12'h000, CORE_HOLD}, 13'h0000);
    // Timer disabled outside crystal modes: no delay at all
    @(posedge CORE_CLK);
    BROWNOUT_DETECT_ENABLE <= 1'h1;
    POWERUP_TIMER_DISABLE <= 1'h1;
    ev(0);
    ld(`PC_RESET);
    chk({12'h000, hold_n <= 3}, 13'h0001);
    // Wake with interrupts disabled: the next step must not branch to the vector
    @(posedge CORE_CLK);
    GLOBAL_INTERRUPT_ENABLE <= 1'h0;
    SLEEPING <= 1'h1;
    ev(2);
    ld(13'h0124);
    @(posedge CORE_CLK);
    SLEEPING <= 1'h0;
    ev(3);
    #1;
    chk({12'h000, PC_LOAD}, 13'h0000);
    // Crystal wake-up with the timer off waits the oscillator count alone
    @(posedge CORE_CLK);
    CRYSTAL_MODE <= 1'h1;
    SLEEPING <= 1'h1;
    ev(1);
    ld(13'h0124);
    chk({12'h000, tick_n >= 1024 && tick_n <= 1026}, 13'h0001);
    // Clock enable low freezes the registers, so the write is lost
    @(posedge CORE_CLK);
    SLEEPING <= 1'h0;
    CLK_EN <= 1'h0;
    wr(8'h81, 8'h12);
    @(posedge CORE_CLK);
    CLK_EN <= 1'h1;
    rd(8'h81, 8'hff);
    final_report;
  end
endmodule
